// ==== rtl/tfm_pkg.sv ====
package tfm_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    // One unit at 150 words per minute: 15 characters of 10 units per second
    localparam int UNIT_TIME_NS = 6_666_667;
    localparam int UNIT_CYCLES = UNIT_TIME_NS / CLK_PERIOD_NS;
    localparam int UNITS_PER_CHAR = 10;
    localparam int DATA_BITS = 8;
    // Character-detected falls at the sample of this data bit (0 = first)
    localparam int DET_CLEAR_BIT = 2;

    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_FEED_LEN = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_RX_CHAR = 8'h10;

    // Reset values
    localparam logic [15:0] FEED_LEN_RST = 16'h0040;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // Status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_MOTOR = 1;
    localparam int ST_LOW_TAPE = 2;
    localparam int ST_RX_BUSY = 3;

    // Interrupt status / mask fields
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_CHAR = 1;
    localparam int IRQ_LOW_TAPE = 2;
    localparam int IRQ_DROPPED = 3;

    // Synchroniser lanes
    localparam int IN_W = 5;
    localparam int IN_MANUAL = 0;
    localparam int IN_REQ_N = 1;
    localparam int IN_MOTOR_N = 2;
    localparam int IN_RX = 3;
    localparam int IN_LOW_TAPE = 4;

    // Delete code: all eight levels marking
    localparam logic [7:0] DELETE_CHAR = 8'hFF;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tfm_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } tfm_rx_char_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } tfm_rx_state_t;

    typedef enum logic {
        FD_IDLE = 1'b0,
        FD_RUN = 1'b1
    } tfm_feed_state_t;

endpackage

// ==== rtl/tfm_char_rx.sv ====
`timescale 1ns/1ps
`default_nettype none

module tfm_char_rx #(
    parameter int UNIT_CYCLES = tfm_pkg::UNIT_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic rx_in,
    output tfm_pkg::tfm_rx_char_t char_out,
    output logic char_det_out,
    output logic busy_out
);
    localparam logic [31:0] UNIT_LAST = 32'(UNIT_CYCLES - 1);
    localparam logic [31:0] HALF_LAST = 32'(UNIT_CYCLES / 2 - 1);

    tfm_pkg::tfm_rx_state_t state_q;
    logic [31:0] tmr_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic det_q;
    tfm_pkg::tfm_rx_char_t char_q;

    // Space (start) is high on the line; mark is low and means a one
    wire tick = (tmr_q == 32'h0000_0000);
    wire mark = !rx_in;
    wire last_bit = (bit_q == 3'(tfm_pkg::DATA_BITS - 1));
    wire det_clear = (state_q == tfm_pkg::RX_DATA) && tick &&
        (bit_q == 3'(tfm_pkg::DET_CLEAR_BIT));

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            state_q <= tfm_pkg::RX_IDLE;
            tmr_q <= 32'h0000_0000;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
            det_q <= 1'b0;
            char_q <= '0;
        end else begin
            char_q.valid <= 1'b0;
            tmr_q <= tick ? 32'h0000_0000 : tmr_q - 32'h0000_0001;
            case (state_q)
                tfm_pkg::RX_IDLE: begin
                    if (!mark) begin
                        state_q <= tfm_pkg::RX_START;
                        tmr_q <= HALF_LAST;
                    end
                end
                tfm_pkg::RX_START: begin
                    if (tick) begin
                        // A glitch shorter than half a unit is not a start
                        state_q <= mark ? tfm_pkg::RX_IDLE : tfm_pkg::RX_DATA;
                        det_q <= !mark; // [RQ2]
                        tmr_q <= UNIT_LAST;
                        bit_q <= 3'h0;
                    end
                end
                tfm_pkg::RX_DATA: begin
                    if (tick) begin
                        shift_q <= {mark, shift_q[7:1]}; // [RQ9]
                        tmr_q <= UNIT_LAST;
                        bit_q <= bit_q + 3'h1;
                        if (det_clear) begin
                            det_q <= 1'b0; // [RQ2]
                        end
                        if (last_bit) begin
                            state_q <= tfm_pkg::RX_STOP;
                        end
                    end
                end
                tfm_pkg::RX_STOP: begin
                    if (tick) begin
                        // The one stop unit must be mark; a framing error drops it
                        char_q.valid <= mark; // [RQ9]
                        char_q.data <= shift_q;
                        state_q <= tfm_pkg::RX_IDLE;
                    end
                end
                default: state_q <= tfm_pkg::RX_IDLE;
            endcase
        end
    end

    assign char_out = char_q;
    assign char_det_out = det_q;
    assign busy_out = (state_q != tfm_pkg::RX_IDLE);

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    property p_det_fall_window;
        $fell(det_q) |-> $past(state_q) == tfm_pkg::RX_DATA &&
            $past(bit_q) == 3'(tfm_pkg::DET_CLEAR_BIT);
    endproperty
    a_det_fall_window: assert property (p_det_fall_window) // [RQ2]
        else $error("character detect fell outside its window");

    property p_det_low_idle;
        state_q == tfm_pkg::RX_IDLE |-> !det_q;
    endproperty
    a_det_low_idle: assert property (p_det_low_idle) // [RQ2]
        else $error("character detect high while idle");

    property p_valid_after_stop;
        char_q.valid |-> $past(state_q) == tfm_pkg::RX_STOP && $past(mark);
    endproperty
    a_valid_after_stop: assert property (p_valid_after_stop) // [RQ9]
        else $error("character delivered without a stop unit");
endmodule

`default_nettype wire

// ==== rtl/tfm_feedout_ctrl.sv ====
// Function
// RQ1: Manual feedout input idle when low; rising edge requests a feedout.
// RQ2: Character-detected normally low; falls between second and eighth bit.
// RQ3: Send-data, spare and both unattended-mode outputs held constantly low.
// RQ4: Motor runs while motor-control is low, stops while high; the code also runs it through any feedout while high.
// RQ5: Controller holds feedout request low 50 ms; falling edge is a request.
// RQ6: Feedout-in-progress high when idle, low for the whole feedout cycle.
// RQ7: Low-tape output high normally, low while tape-supply-low is sensed.
// RQ8: Auxiliary use: primary holds request low until in-progress goes low.
// RQ9: Receive ten-unit start-stop characters at 150 words per minute.
// RQ10: At power-up, run the motor and one feedout cycle unprompted.
// RQ11: Every feedout cycle punches delete characters, all eight levels mark.
// RQ12: Motor stops after a feedout unless motor-control still says run.
// RQ13: Grounded manual line does nothing; its release starts a feedout.
// RQ14: Feedout length set by a counter register; requests ignored meanwhile.
// RQ15: Synchronise every interface input and detect edges on synced copies.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module tfm_feedout_ctrl #(
    parameter int UNIT_CYCLES = tfm_pkg::UNIT_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire tfm_pkg::tfm_bus_req_t bus_in,
    output logic [31:0] rd_data_out,
    input wire logic manual_feed_in,
    input wire logic feed_req_n_in,
    input wire logic motor_ctl_n_in,
    input wire logic rx_data_in,
    input wire logic low_tape_in,
    output logic motor_run_out,
    output logic feed_busy_n_out,
    output logic char_det_out,
    output logic low_tape_n_out,
    output logic send_data_out,
    output logic spare_out,
    output logic unattended_a_out,
    output logic unattended_b_out,
    output logic punch_strobe_out,
    output logic [7:0] punch_data_out,
    output logic irq_out
);
    localparam int CHAR_CYCLES = UNIT_CYCLES * tfm_pkg::UNITS_PER_CHAR;
    localparam logic [31:0] CHAR_LAST = 32'(CHAR_CYCLES - 1);

    function automatic logic rise(input logic cur, input logic prev);
        rise = cur && !prev;
    endfunction

    logic [tfm_pkg::IN_W-1:0] sync1_q;
    logic [tfm_pkg::IN_W-1:0] sync2_q;
    logic [tfm_pkg::IN_W-1:0] prev_q;
    tfm_pkg::tfm_feed_state_t feed_q;
    logic [15:0] feed_len_q;
    logic [15:0] feed_left_q;
    logic [31:0] ctimer_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [7:0] rx_char_q;
    logic [31:0] rd_data_q;
    logic motor_q;
    logic busy_n_q;
    logic low_tape_n_q;
    logic const_low_q;
    logic strobe_q;
    logic [7:0] pdata_q;
    logic irq_q;
    tfm_pkg::tfm_rx_char_t rx_char;
    logic rx_det;
    logic rx_busy;

    tfm_char_rx #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_rx (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .rx_in(sync2_q[tfm_pkg::IN_RX]),
        .char_out(rx_char),
        .char_det_out(rx_det),
        .busy_out(rx_busy)
    );

    // Request decode on synchronised copies only
    wire manual_rise = rise(sync2_q[tfm_pkg::IN_MANUAL],
        prev_q[tfm_pkg::IN_MANUAL]); // [RQ1] [RQ13] [RQ15]
    wire auto_fall = rise(!sync2_q[tfm_pkg::IN_REQ_N],
        !prev_q[tfm_pkg::IN_REQ_N]); // [RQ5] [RQ8] [RQ15]
    wire request = manual_rise || auto_fall;
    wire running = (feed_q == tfm_pkg::FD_RUN);
    wire start = request && !running; // [RQ14]
    wire dropped = request && running; // [RQ14]
    wire char_tick = running && (ctimer_q == 32'h0000_0000);
    wire feed_end = char_tick && (feed_left_q == 16'h0000);
    wire feed_punch = char_tick && (feed_left_q != 16'h0000);
    wire rx_punch = rx_char.valid && !running;
    wire motor_d = !sync2_q[tfm_pkg::IN_MOTOR_N] || running; // [RQ4] [RQ12]
    wire low_tape = sync2_q[tfm_pkg::IN_LOW_TAPE];
    wire low_tape_rise = rise(low_tape, prev_q[tfm_pkg::IN_LOW_TAPE]);

    // Register port decode
    wire wr_len = bus_in.wr && (bus_in.addr == tfm_pkg::REG_FEED_LEN);
    wire wr_clr = bus_in.wr && (bus_in.addr == tfm_pkg::REG_IRQ_STAT);
    wire wr_mask = bus_in.wr && (bus_in.addr == tfm_pkg::REG_IRQ_MASK);
    wire [3:0] irq_clr = wr_clr ? bus_in.wdata[3:0] : 4'h0;
    wire [3:0] irq_set = {dropped, low_tape_rise, rx_char.valid, feed_end};
    wire [3:0] irq_d = (irq_stat_q & ~irq_clr) | irq_set;
    wire [3:0] status = {rx_busy, low_tape, motor_q, running};
    wire [31:0] rd_mux =
        (bus_in.addr == tfm_pkg::REG_FEED_LEN) ? {16'h0000, feed_len_q} :
        (bus_in.addr == tfm_pkg::REG_STATUS) ? {28'h000_0000, status} :
        (bus_in.addr == tfm_pkg::REG_IRQ_STAT) ? {28'h000_0000, irq_stat_q} :
        (bus_in.addr == tfm_pkg::REG_IRQ_MASK) ? {28'h000_0000, irq_mask_q} :
        (bus_in.addr == tfm_pkg::REG_RX_CHAR) ? {24'h00_0000, rx_char_q} :
        32'h0000_0000;

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= {low_tape_in, rx_data_in, motor_ctl_n_in,
                feed_req_n_in, manual_feed_in}; // [RQ15]
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Reset leaves the machine running one cycle of default length
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            feed_q <= tfm_pkg::FD_RUN; // [RQ10]
            feed_left_q <= tfm_pkg::FEED_LEN_RST;
            ctimer_q <= 32'h0000_0000;
        end else if (start) begin
            feed_q <= tfm_pkg::FD_RUN;
            feed_left_q <= feed_len_q; // [RQ14]
            ctimer_q <= 32'h0000_0000;
        end else if (feed_end) begin
            feed_q <= tfm_pkg::FD_IDLE;
        end else if (feed_punch) begin
            feed_left_q <= feed_left_q - 16'h0001;
            ctimer_q <= CHAR_LAST;
        end else if (running) begin
            ctimer_q <= ctimer_q - 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            feed_len_q <= tfm_pkg::FEED_LEN_RST;
            irq_stat_q <= 4'h0;
            irq_mask_q <= tfm_pkg::IRQ_MASK_RST;
            rx_char_q <= 8'h00;
            rd_data_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end else begin
            if (wr_len) begin
                feed_len_q <= bus_in.wdata[15:0]; // [RQ14]
            end
            if (wr_mask) begin
                irq_mask_q <= bus_in.wdata[3:0];
            end
            if (rx_char.valid) begin
                rx_char_q <= rx_char.data;
            end
            // A set in the same cycle as its clear wins
            irq_stat_q <= irq_d;
            irq_q <= |(irq_d & irq_mask_q);
            rd_data_q <= bus_in.rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Motor is already on through a power-up feedout
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            motor_q <= 1'b1; // [RQ10]
            busy_n_q <= 1'b0;
            low_tape_n_q <= 1'b1;
            const_low_q <= 1'b0;
            strobe_q <= 1'b0;
            pdata_q <= 8'h00;
        end else begin
            motor_q <= motor_d; // [RQ4] [RQ12]
            busy_n_q <= !(start || (running && !feed_end)); // [RQ6]
            low_tape_n_q <= !low_tape; // [RQ7]
            const_low_q <= 1'b0; // [RQ3]
            // A character that lands during a feedout is kept, not punched
            strobe_q <= feed_punch || rx_punch;
            pdata_q <= feed_punch ? tfm_pkg::DELETE_CHAR : // [RQ11]
                rx_char.data;
        end
    end

    assign rd_data_out = rd_data_q;
    assign motor_run_out = motor_q;
    assign feed_busy_n_out = busy_n_q;
    assign char_det_out = rx_det;
    assign low_tape_n_out = low_tape_n_q;
    assign send_data_out = const_low_q;
    assign spare_out = const_low_q;
    assign unattended_a_out = const_low_q;
    assign unattended_b_out = const_low_q;
    assign punch_strobe_out = strobe_q;
    assign punch_data_out = pdata_q;
    assign irq_out = irq_q;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    property p_manual_start;
        manual_rise && !running |=> running && !feed_busy_n_out;
    endproperty
    a_manual_start: assert property (p_manual_start) // [RQ1]
        else $error("manual request did not start a feedout");

    property p_auto_start;
        $fell(sync2_q[tfm_pkg::IN_REQ_N]) && !running |=> running;
    endproperty
    a_auto_start: assert property (p_auto_start) // [RQ5]
        else $error("feedout request edge did not start a feedout");

    property p_busy_tracks;
        running && !feed_end |=> !feed_busy_n_out;
    endproperty
    a_busy_tracks: assert property (p_busy_tracks) // [RQ6]
        else $error("in-progress not low during feedout");

    property p_busy_idle;
        !running && !start |=> feed_busy_n_out;
    endproperty
    a_busy_idle: assert property (p_busy_idle) // [RQ6]
        else $error("in-progress low while idle");

    property p_const_low;
        !send_data_out && !spare_out && !unattended_a_out &&
            !unattended_b_out;
    endproperty
    a_const_low: assert property (p_const_low) // [RQ3]
        else $error("fixed-level output not low");

    property p_motor_run;
        !sync2_q[tfm_pkg::IN_MOTOR_N] |=> motor_run_out;
    endproperty
    a_motor_run: assert property (p_motor_run) // [RQ4]
        else $error("motor not running under run command");

    property p_motor_off_after;
        $fell(running) && sync2_q[tfm_pkg::IN_MOTOR_N] |=> !motor_run_out;
    endproperty
    a_motor_off_after: assert property (p_motor_off_after) // [RQ12]
        else $error("motor left on after feedout");

    property p_low_tape;
        low_tape |=> !low_tape_n_out;
    endproperty
    a_low_tape: assert property (p_low_tape) // [RQ7]
        else $error("low-tape output not low");

    property p_delete_punch;
        punch_strobe_out && $past(running) |-> punch_data_out == 8'hFF;
    endproperty
    a_delete_punch: assert property (p_delete_punch) // [RQ11]
        else $error("feedout punched a non-delete character");

    property p_ignore_busy;
        running && request |=> $past(feed_left_q) == feed_left_q ||
            $past(feed_left_q) == feed_left_q + 16'h0001;
    endproperty
    a_ignore_busy: assert property (p_ignore_busy) // [RQ14]
        else $error("request restarted a running feedout");

    property p_powerup;
        !$past(resetn_in) |-> running && motor_run_out;
    endproperty
    a_powerup: assert property (p_powerup) // [RQ10]
        else $error("no feedout at power-up");

    property p_grounded;
        !sync2_q[tfm_pkg::IN_MANUAL] && !prev_q[tfm_pkg::IN_MANUAL] &&
            !auto_fall && !running |=> !running;
    endproperty
    a_grounded: assert property (p_grounded) // [RQ13]
        else $error("grounded manual line started a feedout");

    property p_drop_flag;
        running && request |=> irq_stat_q[tfm_pkg::IRQ_DROPPED];
    endproperty
    a_drop_flag: assert property (p_drop_flag) // [RQ14]
        else $error("request during feedout not flagged");

    property p_char_punch;
        rx_char.valid && !running |=> punch_strobe_out &&
            punch_data_out == $past(rx_char.data);
    endproperty
    a_char_punch: assert property (p_char_punch) // [RQ9]
        else $error("received character not punched");

    property p_low_tape_clear;
        !low_tape |=> low_tape_n_out;
    endproperty
    a_low_tape_clear: assert property (p_low_tape_clear) // [RQ7]
        else $error("low-tape output low without low tape");
endmodule

`default_nettype wire

// ==== verif/tfm_station_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module tfm_station_model #(
    parameter int UNIT_CYCLES = 20,
    // 50 ms at 50 MHz; the bench scales it down to keep runs short
    parameter int REQ_HOLD_CYCLES = 2_500_000
) (
    input wire logic core_clk_in,
    input wire logic req_cmd_in,
    input wire logic run_cmd_in,
    input wire logic send_cmd_in,
    input wire logic [7:0] char_in,
    input wire logic feed_busy_n_in,
    output logic feed_req_n_out,
    output logic motor_ctl_n_out,
    output logic rx_data_out,
    output logic idle_out
);
    logic [9:0] frame;
    int cnt;

    initial begin
        // Unplugged levels: motor stop, receive line at ground
        feed_req_n_out = 1'b1;
        motor_ctl_n_out = 1'b1;
        rx_data_out = 1'b0;
        idle_out = 1'b1;
        forever begin
            @(posedge core_clk_in);
            motor_ctl_n_out <= !run_cmd_in;
            if (req_cmd_in) begin
                idle_out <= 1'b0;
                feed_req_n_out <= 1'b0;
                cnt = 0;
                // Held for the minimum, and until busy clears it
                while ((cnt < REQ_HOLD_CYCLES || feed_busy_n_in !== 1'b0)
                       && cnt < REQ_HOLD_CYCLES + 1000) begin
                    @(posedge core_clk_in);
                    cnt++;
                end
                feed_req_n_out <= 1'b1;
                idle_out <= 1'b1;
            end else if (send_cmd_in) begin
                idle_out <= 1'b0;
                // Space start, data LSB first with mark low, mark stop
                frame = {1'b0, ~char_in, 1'b1};
                for (int u = 0; u < 10; u++) begin
                    rx_data_out <= frame[u];
                    repeat (UNIT_CYCLES) @(posedge core_clk_in);
                end
                idle_out <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ==== verif/tfm_feedout_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tfm_feedout_ctrl_tb;
    localparam int U = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    tfm_pkg::tfm_bus_req_t bus = '0;
    logic manual = 1'b0;
    logic low_tape = 1'b0;
    logic req_cmd = 1'b0;
    logic run_cmd = 1'b0;
    logic send_cmd = 1'b0;
    logic [7:0] tx_char = 8'h00;
    wire logic req_n, motor_n, rx, model_idle;
    logic [31:0] rd_data, d;
    logic motor, busy_n, det, low_tape_n, send_d, spare, un_a, un_b;
    logic strobe, irq;
    logic [7:0] pdata;
    int fails = 0;
    int check_count = 0;

    always #10 clk = ~clk;

    tfm_feedout_ctrl #(.UNIT_CYCLES(U)) i_tfm_feedout_ctrl (
        .core_clk_in(clk), .resetn_in(resetn), .bus_in(bus),
        .rd_data_out(rd_data), .manual_feed_in(manual),
        .feed_req_n_in(req_n), .motor_ctl_n_in(motor_n),
        .rx_data_in(rx), .low_tape_in(low_tape), .motor_run_out(motor),
        .feed_busy_n_out(busy_n), .char_det_out(det),
        .low_tape_n_out(low_tape_n), .send_data_out(send_d),
        .spare_out(spare), .unattended_a_out(un_a),
        .unattended_b_out(un_b), .punch_strobe_out(strobe),
        .punch_data_out(pdata), .irq_out(irq));

    tfm_station_model #(.UNIT_CYCLES(U), .REQ_HOLD_CYCLES(16))
        i_tfm_station_model (
        .core_clk_in(clk), .req_cmd_in(req_cmd), .run_cmd_in(run_cmd),
        .send_cmd_in(send_cmd), .char_in(tx_char),
        .feed_busy_n_in(busy_n), .feed_req_n_out(req_n),
        .motor_ctl_n_out(motor_n), .rx_data_out(rx),
        .idle_out(model_idle));

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic fixed_outs;
        chk("fixed outputs", {28'h000_0000, send_d, spare, un_a, un_b},
            32'h0000_0000);
    endtask

    // Busy is expected low from the first strobe for n character times
    task automatic run_feed(input int n);
        int k, len, st;
        k = 0;
        while (strobe !== 1'b1 && k < 30) begin
            tick;
            k++;
        end
        len = 0;
        st = 0;
        while (busy_n === 1'b0 && len < n * 10 * U + 50) begin
            if (strobe === 1'b1) begin
                st++;
                chk("punch data", pdata, 32'h0000_00FF);
                chk("motor in feedout", motor, 1'b1);
            end
            len++;
            tick;
        end
        chk("strobe count", st, n);
        chk("busy length", len, n * 10 * U);
        fixed_outs;
    endtask

    task automatic t_powerup;
        chk("busy at release", busy_n, 1'b0);
        chk("motor at release", motor, 1'b1);
        run_feed(64);
        tick;
        chk("motor after feed", motor, 1'b0);
        chk("low tape idle", low_tape_n, 1'b1);
        chk("det idle", det, 1'b0);
    endtask

    task automatic t_regs;
        reg_rd(8'h00);
        chk("len reset", d, 32'h0000_0040);
        reg_rd(8'h0C);
        chk("mask reset", d, 32'h0000_0000);
        tick;
        chk("read data released", rd_data, 32'h0000_0000);
        reg_wr(8'h00, 32'h0000_0003);
        reg_wr(8'h20, 32'hFFFF_FFFF);
        reg_rd(8'h00);
        chk("len written", d, 32'h0000_0003);
        reg_rd(8'h20);
        chk("unmapped", d, 32'h0000_0000);
        reg_rd(8'h04);
        chk("status idle", d, 32'h0000_0000);
        reg_wr(8'h08, 32'h0000_000F);
        reg_rd(8'h08);
        chk("irq cleared", d, 32'h0000_0000);
    endtask

    task automatic t_manual;
        repeat (40) tick;
        chk("grounded manual", busy_n, 1'b1);
        @(posedge clk);
        manual <= 1'b1;
        repeat (2) tick;
        chk("busy early", busy_n, 1'b1);
        tick;
        chk("busy start", busy_n, 1'b0);
        fork
            run_feed(3);
            begin
                repeat (20) @(posedge clk);
                manual <= 1'b0;
                repeat (20) @(posedge clk);
                manual <= 1'b1;
                repeat (20) @(posedge clk);
                manual <= 1'b0;
            end
        join
        tick;
        chk("motor off", motor, 1'b0);
        repeat (20) tick;
        chk("no queued feed", busy_n, 1'b1);
        reg_rd(8'h08);
        chk("done and dropped", d, 32'h0000_0009);
        reg_wr(8'h0C, 32'h0000_0001);
        repeat (2) tick;
        chk("irq raised", irq, 1'b1);
        reg_wr(8'h0C, 32'h0000_0008);
        repeat (2) tick;
        chk("irq raised b3", irq, 1'b1);
        reg_wr(8'h08, 32'h0000_0008);
        repeat (2) tick;
        chk("irq masked", irq, 1'b0);
        reg_wr(8'h08, 32'h0000_0001);
        reg_rd(8'h08);
        chk("irq stat clear", d, 32'h0000_0000);
    endtask

    task automatic t_auto;
        @(posedge clk);
        run_cmd <= 1'b1;
        repeat (6) tick;
        chk("motor run", motor, 1'b1);
        @(posedge clk);
        req_cmd <= 1'b1;
        @(posedge clk);
        req_cmd <= 1'b0;
        run_feed(3);
        tick;
        chk("motor kept", motor, 1'b1);
        chk("request released", req_n, 1'b1);
        @(posedge clk);
        run_cmd <= 1'b0;
        repeat (6) tick;
        chk("motor stop", motor, 1'b0);
    endtask

    task automatic t_rx;
        logic [7:0] chars [2] = '{8'h41, 8'hA5};
        int n, fall, rose, seen;
        reg_wr(8'h08, 32'h0000_000F);
        foreach (chars[i]) begin
            @(posedge clk);
            tx_char <= chars[i];
            send_cmd <= 1'b1;
            @(posedge clk);
            send_cmd <= 1'b0;
            n = 0;
            fall = -1;
            rose = 0;
            seen = 0;
            while (seen == 0 && n < 12 * U) begin
                tick;
                n++;
                if (det === 1'b1)
                    rose = 1;
                if (rose == 1 && det === 1'b0 && fall < 0)
                    fall = n;
                if (strobe === 1'b1) begin
                    seen = 1;
                    chk("rx punch", pdata, chars[i]);
                end
            end
            chk("rx strobe", seen, 1);
            chk("det fall", fall >= 2 * U && fall <= 9 * U + 6, 1);
            reg_rd(8'h10);
            chk("rx char", d, {24'h00_0000, chars[i]});
            n = 0;
            while (model_idle !== 1'b1 && n < 4 * U) begin
                tick;
                n++;
            end
        end
        reg_rd(8'h08);
        chk("char irq", d, 32'h0000_0002);
    endtask

    task automatic t_low_tape;
        @(posedge clk);
        low_tape <= 1'b1;
        repeat (6) tick;
        chk("low tape on", low_tape_n, 1'b0);
        reg_rd(8'h08);
        chk("low tape irq", d & 32'h0000_0004, 32'h0000_0004);
        @(posedge clk);
        low_tape <= 1'b0;
        repeat (6) tick;
        chk("low tape off", low_tape_n, 1'b1);
        fixed_outs;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        $display("Watchdog expired before the tests ended");
        give_verdict;
    end

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        #1;
        t_powerup;
        t_regs;
        t_manual;
        t_auto;
        t_rx;
        t_low_tape;
        give_verdict;
    end
endmodule

`default_nettype wire
